// ===== hdl/epcs_defines.vh
// constants of the encoder position compare and status block
// assumes a 200 MHz system clock and a byte-addressed word register port
`ifndef EPCS_DEFINES_VH
`define EPCS_DEFINES_VH

// ==========================================================================
// timing
`define EPCS_CLK_MHZ            200
`define EPCS_POLL_PERIOD_US     10
`define EPCS_POLL_PERIOD_CYC    (`EPCS_POLL_PERIOD_US * `EPCS_CLK_MHZ)
`define EPCS_REPLY_TIMEOUT_US   2
`define EPCS_REPLY_TIMEOUT_CYC  (`EPCS_REPLY_TIMEOUT_US * `EPCS_CLK_MHZ)

// ==========================================================================
// register offsets
`define EPCS_OFS_CTRL           8'h00
`define EPCS_OFS_CMD            8'h04
`define EPCS_OFS_STATUS         8'h08
`define EPCS_OFS_CMP_A          8'h0C
`define EPCS_OFS_CMP_B          8'h10
`define EPCS_OFS_LOW_LIM        8'h14
`define EPCS_OFS_HIGH_LIM       8'h18
`define EPCS_OFS_POSITION       8'h1C
`define EPCS_OFS_DIAG_EN        8'h20
`define EPCS_OFS_IRQ_STAT       8'h24
`define EPCS_OFS_IRQ_MASK       8'h28

// ==========================================================================
// control and command fields
`define EPCS_CTRL_EN_A          0
`define EPCS_CTRL_EN_B          1
`define EPCS_CTRL_STOP          2
`define EPCS_CTRL_W             3
`define EPCS_CTRL_RST           3'h4
`define EPCS_CMD_CLR_A          0
`define EPCS_CMD_CLR_B          1

// ==========================================================================
// status word fields
`define EPCS_ST_DIR_DOWN        0
`define EPCS_ST_A_GE            1
`define EPCS_ST_A_EQ            2
`define EPCS_ST_A_MATCH         3
`define EPCS_ST_B_GE            4
`define EPCS_ST_B_EQ            5
`define EPCS_ST_B_MATCH         6
`define EPCS_ST_HALTED          7
`define EPCS_ST_PARAM_ERR       8
`define EPCS_ST_BELOW_LOW       9
`define EPCS_ST_ABOVE_HIGH      10
`define EPCS_ST_ENC_FAULT       11
`define EPCS_ST_DIAG            12
`define EPCS_ST_ENC_LSB         16

// ==========================================================================
// interrupt and encoder status widths, limit reset values
`define EPCS_IRQ_W              7
`define EPCS_ENC_ST_W           4
`define EPCS_LIM_LOW_RST        32'h00000000
`define EPCS_LIM_HIGH_RST       32'hFFFFFFFF

`endif

// ===== hdl/epcs_compare_channel.v
// one comparison channel: relational, live equality and latched match
// assumes position and compare value are stable registered words
`timescale 1ns/1ps

module epcs_compare_channel #(
    parameter POS_W = 32
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire             enable,
    input  wire             clear_req,
    input  wire [POS_W-1:0] position,
    input  wire [POS_W-1:0] compare_value,
    output reg              ge_reg,
    output reg              equal_reg,
    output reg              match_reg,
    output wire             match_set
);

    wire ge_now;
    wire eq_now;
    reg  ge_next;
    reg  equal_next;
    reg  match_next;

    // ======================================================================
    // comparison
    assign ge_now    = (position >= compare_value);
    assign eq_now    = (position == compare_value);
    assign match_set = enable & eq_now & ~match_reg;

    always @* begin
        ge_next    = enable & ge_now;
        equal_next = enable & eq_now;
        match_next = match_reg;
        if (clear_req) begin
            match_next = 1'b0;
        end
        if (enable & eq_now) begin
            match_next = 1'b1;
        end
        if (!enable) begin
            match_next = 1'b0;
        end
    end

    // ======================================================================
    // state
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ge_reg    <= 1'b0;
            equal_reg <= 1'b0;
            match_reg <= 1'b0;
        end else begin
            ge_reg    <= ge_next;
            equal_reg <= equal_next;
            match_reg <= match_next;
        end
    end

endmodule // epcs_compare_channel

// ===== hdl/epcs_top.v
// encoder position compare and status block, register port and poll timing
// assumes encoder replies synchronous to SYS_CLK, one-cycle bus strobes
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps
`include "epcs_defines.vh"

module epcs_top #(
    parameter POS_W          = 32,
    parameter POLL_PERIOD    = `EPCS_POLL_PERIOD_CYC,
    parameter REPLY_TIMEOUT  = `EPCS_REPLY_TIMEOUT_CYC
) (
    input  wire                      SYS_CLK,
    input  wire                      NRST,
    input  wire [7:0]                REG_ADDR,
    input  wire [31:0]               REG_WDATA,
    input  wire                      REG_WR,
    input  wire                      REG_RD,
    output reg  [31:0]               REG_RDATA,
    output reg                       ENC_POLL_REQ,
    input  wire                      ENC_POS_VALID,
    input  wire [POS_W-1:0]          ENC_POS,
    input  wire [`EPCS_ENC_ST_W-1:0] ENC_STATUS,
    input  wire                      ENC_SIGNAL_OK,
    output reg                       DOWN_LAMP,
    output reg                       POLLING_HALTED,
    output reg                       IRQ
);

    // ======================================================================
    // declarations
    reg                       rst_meta_reg;
    reg                       rst_sync_reg;
    wire                      rst_n;

    reg  [`EPCS_CTRL_W-1:0]   ctrl_reg;
    reg  [POS_W-1:0]          compare_value_a;
    reg  [POS_W-1:0]          compare_value_b;
    reg  [POS_W-1:0]          low_limit_value;
    reg  [POS_W-1:0]          high_limit_value;
    reg  [`EPCS_ENC_ST_W-1:0] diag_enable_reg;
    reg  [`EPCS_IRQ_W-1:0]    irq_stat_reg;
    reg  [`EPCS_IRQ_W-1:0]    irq_stat_next;
    reg  [`EPCS_IRQ_W-1:0]    irq_mask_reg;

    reg  [POS_W-1:0]          current_position;
    reg  [`EPCS_ENC_ST_W-1:0] encoder_status_bits;
    reg                       dir_down_ind;
    reg                       param_set_error;
    reg                       below_low_limit;
    reg                       above_high_limit;
    reg                       encoder_signal_fault;
    reg                       encoder_diag_summary;
    reg                       reply_timeout_reg;

    reg  [15:0]               poll_cnt_reg;
    reg  [15:0]               wait_cnt_reg;
    reg  [1:0]                poll_state_reg;
    reg  [1:0]                poll_state_next;

    reg  [`EPCS_IRQ_W-1:0]    events_prev_reg;
    wire [`EPCS_IRQ_W-1:0]    events_now;
    wire [`EPCS_IRQ_W-1:0]    events_rise;

    wire                      wr_ctrl;
    wire                      wr_cmd;
    wire                      clear_match_a;
    wire                      clear_match_b;
    wire                      compare_a_enable;
    wire                      compare_b_enable;
    wire                      stop_req;
    wire                      halt_now;
    wire                      pos_take;
    wire                      cmp_a_ge;
    wire                      cmp_a_equal_live;
    wire                      cmp_a_match_latched;
    wire                      cmp_a_set;
    wire                      cmp_b_ge;
    wire                      cmp_b_equal_live;
    wire                      cmp_b_match_latched;
    wire                      cmp_b_set;
    wire [31:0]               status_word;
    reg  [31:0]               rdata_next;

    localparam [1:0] PS_IDLE  = 2'h0;
    localparam [1:0] PS_WAIT  = 2'h1;
    localparam [1:0] PS_HALT  = 2'h2;

    localparam [15:0] POLL_LAST = POLL_PERIOD - 1;
    localparam [15:0] WAIT_LAST = REPLY_TIMEOUT - 1;

    // ======================================================================
    // functions
    function [31:0] to_word;
        input [POS_W-1:0] value;
        begin
            to_word = 32'h00000000;
            to_word[POS_W-1:0] = value;
        end
    endfunction

    function [POS_W-1:0] from_word;
        input [31:0] value;
        begin
            from_word = value[POS_W-1:0];
        end
    endfunction

    // ======================================================================
    // reset synchroniser
    always @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    assign rst_n = rst_sync_reg;

    // ======================================================================
    // register writes
    assign wr_ctrl          = REG_WR & (REG_ADDR == `EPCS_OFS_CTRL);
    assign wr_cmd           = REG_WR & (REG_ADDR == `EPCS_OFS_CMD);
    assign clear_match_a    = wr_cmd & REG_WDATA[`EPCS_CMD_CLR_A];
    assign clear_match_b    = wr_cmd & REG_WDATA[`EPCS_CMD_CLR_B];
    assign compare_a_enable = ctrl_reg[`EPCS_CTRL_EN_A];
    assign compare_b_enable = ctrl_reg[`EPCS_CTRL_EN_B];
    assign stop_req         = ctrl_reg[`EPCS_CTRL_STOP];

    always @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg         <= `EPCS_CTRL_RST;
            compare_value_a  <= {POS_W{1'b0}};
            compare_value_b  <= {POS_W{1'b0}};
            low_limit_value  <= from_word(`EPCS_LIM_LOW_RST);
            high_limit_value <= from_word(`EPCS_LIM_HIGH_RST);
            diag_enable_reg  <= {`EPCS_ENC_ST_W{1'b0}};
            irq_mask_reg     <= {`EPCS_IRQ_W{1'b0}};
        end else if (REG_WR) begin
            case (REG_ADDR)
                `EPCS_OFS_CTRL:     ctrl_reg         <= REG_WDATA[`EPCS_CTRL_W-1:0];
                `EPCS_OFS_CMP_A:    compare_value_a  <= from_word(REG_WDATA);
                `EPCS_OFS_CMP_B:    compare_value_b  <= from_word(REG_WDATA);
                `EPCS_OFS_LOW_LIM:  low_limit_value  <= from_word(REG_WDATA);
                `EPCS_OFS_HIGH_LIM: high_limit_value <= from_word(REG_WDATA);
                `EPCS_OFS_DIAG_EN:  diag_enable_reg  <= REG_WDATA[`EPCS_ENC_ST_W-1:0];
                `EPCS_OFS_IRQ_MASK: irq_mask_reg     <= REG_WDATA[`EPCS_IRQ_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // ======================================================================
    // parameter check and halt
    always @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            param_set_error <= 1'b0;
        end else begin
            param_set_error <= (low_limit_value > high_limit_value);
        end
    end

    assign halt_now = stop_req | param_set_error;

    // ======================================================================
    // encoder poll sequencer
    always @* begin
        poll_state_next = poll_state_reg;
        case (poll_state_reg)
            PS_IDLE: begin
                if (halt_now) begin
                    poll_state_next = PS_HALT;
                end else if (poll_cnt_reg == POLL_LAST) begin
                    poll_state_next = PS_WAIT;
                end
            end
            PS_WAIT: begin
                if (halt_now) begin
                    poll_state_next = PS_HALT;
                end else if (ENC_POS_VALID || wait_cnt_reg == WAIT_LAST) begin
                    poll_state_next = PS_IDLE;
                end
            end
            PS_HALT: begin
                if (!halt_now) begin
                    poll_state_next = PS_IDLE;
                end
            end
            default: begin
                poll_state_next = PS_HALT;
            end
        endcase
    end

    always @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            poll_state_reg <= PS_HALT;
            poll_cnt_reg   <= 16'h0000;
            wait_cnt_reg   <= 16'h0000;
            ENC_POLL_REQ   <= 1'b0;
            POLLING_HALTED <= 1'b1;
        end else begin
            poll_state_reg <= poll_state_next;
            ENC_POLL_REQ   <= (poll_state_reg == PS_IDLE) & ~halt_now
                              & (poll_cnt_reg == POLL_LAST);
            POLLING_HALTED <= halt_now;
            if (poll_state_reg == PS_IDLE && !halt_now && poll_cnt_reg != POLL_LAST) begin
                poll_cnt_reg <= poll_cnt_reg + 16'h0001;
            end else begin
                poll_cnt_reg <= 16'h0000;
            end
            if (poll_state_reg == PS_WAIT) begin
                wait_cnt_reg <= wait_cnt_reg + 16'h0001;
            end else begin
                wait_cnt_reg <= 16'h0000;
            end
        end
    end

    // ======================================================================
    // position capture and live status
    assign pos_take = ENC_POS_VALID & (poll_state_reg == PS_WAIT) & ~halt_now;

    always @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            current_position     <= {POS_W{1'b0}};
            encoder_status_bits  <= {`EPCS_ENC_ST_W{1'b0}};
            dir_down_ind         <= 1'b0;
            DOWN_LAMP            <= 1'b0;
            reply_timeout_reg    <= 1'b0;
            encoder_signal_fault <= 1'b0;
            encoder_diag_summary <= 1'b0;
            below_low_limit      <= 1'b0;
            above_high_limit     <= 1'b0;
        end else begin
            if (pos_take) begin
                current_position    <= ENC_POS;
                encoder_status_bits <= ENC_STATUS;
                dir_down_ind        <= (ENC_POS < current_position);
                DOWN_LAMP           <= (ENC_POS < current_position);
                reply_timeout_reg   <= 1'b0;
            end else if (poll_state_reg == PS_WAIT && wait_cnt_reg == WAIT_LAST) begin
                reply_timeout_reg   <= 1'b1;
            end
            encoder_signal_fault <= ~ENC_SIGNAL_OK | reply_timeout_reg;
            encoder_diag_summary <= |(encoder_status_bits & diag_enable_reg);
            below_low_limit      <= (current_position < low_limit_value);
            above_high_limit     <= (current_position > high_limit_value);
        end
    end

    // ======================================================================
    // comparison channels
    epcs_compare_channel #(
        .POS_W         (POS_W)
    ) u_cmp_a (
        .clk           (SYS_CLK),
        .rst_n         (rst_n),
        .enable        (compare_a_enable),
        .clear_req     (clear_match_a),
        .position      (current_position),
        .compare_value (compare_value_a),
        .ge_reg        (cmp_a_ge),
        .equal_reg     (cmp_a_equal_live),
        .match_reg     (cmp_a_match_latched),
        .match_set     (cmp_a_set)
    );

    epcs_compare_channel #(
        .POS_W         (POS_W)
    ) u_cmp_b (
        .clk           (SYS_CLK),
        .rst_n         (rst_n),
        .enable        (compare_b_enable),
        .clear_req     (clear_match_b),
        .position      (current_position),
        .compare_value (compare_value_b),
        .ge_reg        (cmp_b_ge),
        .equal_reg     (cmp_b_equal_live),
        .match_reg     (cmp_b_match_latched),
        .match_set     (cmp_b_set)
    );

    // ======================================================================
    // interrupts
    assign events_now  = {encoder_diag_summary, above_high_limit, below_low_limit,
                          param_set_error, encoder_signal_fault, 2'b00};
    assign events_rise = (events_now & ~events_prev_reg) | {5'b00000, cmp_b_set, cmp_a_set};

    always @* begin
        irq_stat_next = irq_stat_reg;
        if (REG_WR && REG_ADDR == `EPCS_OFS_IRQ_STAT) begin
            irq_stat_next = irq_stat_next & ~REG_WDATA[`EPCS_IRQ_W-1:0];
        end
        irq_stat_next = irq_stat_next | events_rise;
    end

    always @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            events_prev_reg <= {`EPCS_IRQ_W{1'b0}};
            irq_stat_reg    <= {`EPCS_IRQ_W{1'b0}};
            IRQ             <= 1'b0;
        end else begin
            events_prev_reg <= events_now;
            irq_stat_reg    <= irq_stat_next;
            IRQ             <= |(irq_stat_next & irq_mask_reg);
        end
    end

    // ======================================================================
    // register reads
    assign status_word = {12'h000, encoder_status_bits, 3'b000,
                          encoder_diag_summary, encoder_signal_fault, above_high_limit,
                          below_low_limit, param_set_error, POLLING_HALTED,
                          cmp_b_match_latched, cmp_b_equal_live, cmp_b_ge,
                          cmp_a_match_latched, cmp_a_equal_live, cmp_a_ge, dir_down_ind};

    always @* begin
        rdata_next = 32'h00000000;
        case (REG_ADDR)
            `EPCS_OFS_CTRL:     rdata_next[`EPCS_CTRL_W-1:0] = ctrl_reg;
            `EPCS_OFS_STATUS:   rdata_next = status_word;
            `EPCS_OFS_CMP_A:    rdata_next = to_word(compare_value_a);
            `EPCS_OFS_CMP_B:    rdata_next = to_word(compare_value_b);
            `EPCS_OFS_LOW_LIM:  rdata_next = to_word(low_limit_value);
            `EPCS_OFS_HIGH_LIM: rdata_next = to_word(high_limit_value);
            `EPCS_OFS_POSITION: rdata_next = to_word(current_position);
            `EPCS_OFS_DIAG_EN:  rdata_next[`EPCS_ENC_ST_W-1:0] = diag_enable_reg;
            `EPCS_OFS_IRQ_STAT: rdata_next[`EPCS_IRQ_W-1:0] = irq_stat_reg;
            `EPCS_OFS_IRQ_MASK: rdata_next[`EPCS_IRQ_W-1:0] = irq_mask_reg;
            default: begin
                rdata_next = 32'h00000000;
            end
        endcase
    end

    always @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            REG_RDATA <= 32'h00000000;
        end else if (REG_RD) begin
            REG_RDATA <= rdata_next;
        end else begin
            REG_RDATA <= 32'h00000000;
        end
    end

endmodule // epcs_top

// ===== dv/epcs_top_sva.sv
// assertions on the ports of the position compare and status block
// assumes one-cycle register strobes and the register map of the defines
`timescale 1ns/1ps
`include "epcs_defines.vh"
module epcs_top_sva (
    input wire        SYS_CLK,
    input wire        NRST,
    input wire [7:0]  REG_ADDR,
    input wire [31:0] REG_WDATA,
    input wire        REG_WR,
    input wire        REG_RD,
    input wire [31:0] REG_RDATA,
    input wire        ENC_POLL_REQ,
    input wire        POLLING_HALTED
);
    // ====
    // control shadow and read tracking
    wire      cw = REG_WR && REG_ADDR == `EPCS_OFS_CTRL;
    reg [2:0] ctrl_reg;
    reg [2:0] age_reg;
    reg       rd_reg;
    reg       st_reg;
    always @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            ctrl_reg <= 3'h4;
            age_reg <= 3'h0;
            rd_reg <= 1'b0;
            st_reg <= 1'b0;
        end else begin
            rd_reg <= REG_RD;
            st_reg <= REG_RD && REG_ADDR == `EPCS_OFS_STATUS;
            age_reg <= cw ? 3'h0 : age_reg + {2'h0, age_reg != 3'h7};
            if (cw)
                ctrl_reg <= REG_WDATA[2:0];
        end
    end
    // ====
    // properties
    default clocking dc @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);
    poll_pulse_a: assert property (ENC_POLL_REQ |=> !ENC_POLL_REQ)
        else $error("poll too long");
    halt_no_poll_a: assert property (
        POLLING_HALTED && $past(POLLING_HALTED) |-> !ENC_POLL_REQ) else $error("poll while halted");
    stop_halts_a: assert property (
        age_reg == 3'h7 && ctrl_reg[2] |-> POLLING_HALTED) else $error("stop without halt");
    param_halt_a: assert property (
        st_reg && REG_RDATA[8] |-> POLLING_HALTED) else $error("param error without halt");
    rdata_idle_a: assert property (!rd_reg |-> REG_RDATA == 32'h0)
        else $error("rdata outside read");
    a_eq_ge_a: assert property (
        st_reg && REG_RDATA[2] |-> REG_RDATA[1]) else $error("a equal without ge");
    b_eq_ge_a: assert property (
        st_reg && REG_RDATA[5] |-> REG_RDATA[4]) else $error("b equal without ge");
    a_off_zero_a: assert property (
        st_reg && age_reg == 3'h7 && !ctrl_reg[0] |-> REG_RDATA[3:1] == 3'h0)
        else $error("a bits while off");
    b_off_zero_a: assert property (
        st_reg && age_reg == 3'h7 && !ctrl_reg[1] |-> REG_RDATA[6:4] == 3'h0)
        else $error("b bits while off");
    limits_param_a: assert property (
        st_reg && REG_RDATA[9] && REG_RDATA[10] |-> REG_RDATA[8])
        else $error("both limits crossed without param error");
endmodule // epcs_top_sva

bind epcs_top epcs_top_sva u_epcs_top_sva (.*);

// ===== dv/epcs_enc_model.sv
// encoder stand-in: answers each poll after dly cycles unless muted
// assumes dly stays below the reply timeout of the block
`timescale 1ns/1ps
module epcs_enc_model (
    input wire        clk,
    input wire        poll,
    input wire        mute,
    input wire [3:0]  dly,
    input wire [31:0] pos_in,
    input wire [3:0]  st_in,
    output reg        valid,
    output reg [31:0] pos,
    output reg [3:0]  st
);
    reg [3:0] cnt_reg = 4'h0;
    initial {valid, pos, st} = 37'h0;
    // ====
    // reply timing, idle lines toggle
    always @(posedge clk) begin
        valid <= cnt_reg == 4'h1;
        pos <= (cnt_reg == 4'h1) ? pos_in : ~pos;
        st <= (cnt_reg == 4'h1) ? st_in : ~st;
        if (poll && !mute)
            cnt_reg <= dly;
        else if (cnt_reg != 4'h0)
            cnt_reg <= cnt_reg - 4'h1;
    end
endmodule // epcs_enc_model

// ===== dv/test_epcs_top.sv
// self-checking bench of the position compare and status block
// assumes the encoder stand-in answers inside the shortened timeout
`timescale 1ns/1ps
`include "epcs_defines.vh"
module test_epcs_top;
    reg         SYS_CLK = 1'b0;
    reg         NRST = 1'b0;
    reg  [7:0]  REG_ADDR = 8'h00;
    reg  [31:0] REG_WDATA = 32'h0;
    reg         REG_WR = 1'b0;
    reg         REG_RD = 1'b0;
    reg         ENC_SIGNAL_OK = 1'b1;
    wire [31:0] REG_RDATA, ENC_POS;
    wire [3:0]  ENC_STATUS;
    wire        ENC_POLL_REQ, ENC_POS_VALID, DOWN_LAMP, POLLING_HALTED, IRQ;
    reg  [31:0] pos_in = 32'h0, rnd = 32'h6, cur = 32'h0, lo = 32'h1E, q;
    reg  [3:0]  st_in = 4'h0, dly = 4'h2, dg = 4'h0;
    reg         mute = 1'b0, dn = 1'b0, ma = 1'b0, mb = 1'b0, stop = 1'b1, flt = 1'b0;
    reg  [1:0]  en = 2'h0;
    integer     err_count = 0, n_tests = 0, i, k;
    localparam [31:0]  CA = 32'h64, CB = 32'hC8, HI = 32'hDC;
    localparam [175:0] TBL = {16'h1D, 16'h1E, 16'hDD, 16'hDC, 16'h14, 16'hFA,
                              16'hC8, 16'h64, 16'h96, 16'h64, 16'h32};
    always #2.5 SYS_CLK = ~SYS_CLK;
    epcs_top #(.POLL_PERIOD(8), .REPLY_TIMEOUT(6)) u_epcs_top (.*);
    epcs_enc_model u_epcs_enc_model (.clk(SYS_CLK), .poll(ENC_POLL_REQ), .mute, .dly,
        .pos_in, .st_in, .valid(ENC_POS_VALID), .pos(ENC_POS), .st(ENC_STATUS));
    // ====
    // expectations and bus tasks
    function [31:0] xs(input [31:0] v);
        reg [31:0] t;
        begin
            t = v ^ (v << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    function [31:0] exp_st();
        exp_st = {12'h0, st_in, 3'h0, |(st_in & dg), flt, cur > HI, cur < lo, lo > HI,
                  stop | (lo > HI), en[1] & mb, en[1] & (cur == CB), en[1] & (cur >= CB),
                  en[0] & ma, en[0] & (cur == CA), en[0] & (cur >= CA), dn};
    endfunction
    task chk(input string nm, input [31:0] seen, input [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("unexpected %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge SYS_CLK);
            REG_WR <= 1'b1;
            REG_ADDR <= a;
            REG_WDATA <= d;
            @(posedge SYS_CLK);
            REG_WR <= 1'b0;
        end
    endtask
    task rd(input [7:0] a, output [31:0] d);
        begin
            @(posedge SYS_CLK);
            REG_RD <= 1'b1;
            REG_ADDR <= a;
            @(posedge SYS_CLK);
            REG_RD <= 1'b0;
            #1;
            d = REG_RDATA;
        end
    endtask
    task ctl(input [2:0] c);
        begin
            wr(`EPCS_OFS_CTRL, {29'h0, c});
            en = c[1:0];
            stop = c[2];
        end
    endtask
    task sc(input [31:0] m);
        begin
            rd(`EPCS_OFS_STATUS, q);
            chk("status", q & m, exp_st() & m);
        end
    endtask
    task enc(input [31:0] p);
        begin
            pos_in = p;
            k = 0;
            @(posedge SYS_CLK);
            #1;
            while (ENC_POS_VALID !== 1'b1 && k < 40) begin
                @(posedge SYS_CLK);
                #1;
                k = k + 1;
            end
            chk("reply", {31'h0, ENC_POS_VALID}, 32'h1);
            dn = p < cur;
            cur = p;
            ma = ma | (en[0] & (p == CA));
            mb = mb | (en[1] & (p == CB));
            repeat (4) @(posedge SYS_CLK);
        end
    endtask
    task conclude;
        begin
            $display("checks %0d mismatches %0d", n_tests, err_count);
            if (err_count == 0 && n_tests > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    initial begin
        repeat (20000) @(posedge SYS_CLK);
        err_count = err_count + 1;
        conclude;
    end
    // ====
    // scenarios
    initial begin
        repeat (16) @(posedge SYS_CLK);
        NRST <= 1'b1;
        repeat (3) @(posedge SYS_CLK);
        chk("halted", {31'h0, POLLING_HALTED}, 32'h1);
        rd(`EPCS_OFS_CTRL, q);
        chk("ctrl", q, 32'h4);
        rd(8'h40, q);
        chk("unmapped", q, 32'h0);
        $display("reset test done");
        wr(`EPCS_OFS_CMP_A, CA);
        wr(`EPCS_OFS_CMP_B, CB);
        wr(`EPCS_OFS_LOW_LIM, lo);
        wr(`EPCS_OFS_HIGH_LIM, HI);
        ctl(3'h3);
        for (i = 0; i < 24; i = i + 1) begin
            rnd = xs(rnd);
            dly = rnd[8] ? 4'h4 : 4'h1;
            enc(i < 11 ? {16'h0, TBL[16*i +: 16]} : rnd % 32'h12C);
            chk("lamp", {31'h0, DOWN_LAMP}, {31'h0, dn});
            sc(32'hFFFFFFFF);
        end
        enc(CA);
        wr(`EPCS_OFS_CMD, 32'h3);
        mb = 1'b0;
        sc(32'h48);
        enc(CA + 32'h1);
        wr(`EPCS_OFS_CMD, 32'h1);
        ma = 1'b0;
        sc(32'h48);
        ctl(3'h2);
        enc(CA);
        sc(32'h7F);
        ctl(3'h3);
        ma = 1'b1;
        sc(32'h7F);
        $display("compare test done");
        enc(CA + 32'h14);
        wr(`EPCS_OFS_CMD, 32'h1);
        ma = 1'b0;
        wr(`EPCS_OFS_IRQ_STAT, 32'h7F);
        wr(`EPCS_OFS_IRQ_MASK, 32'h1);
        repeat (2) @(posedge SYS_CLK);
        chk("irq idle", {31'h0, IRQ}, 32'h0);
        enc(CA);
        chk("irq up", {31'h0, IRQ}, 32'h1);
        enc(CA + 32'h14);
        wr(`EPCS_OFS_IRQ_STAT, 32'h1);
        repeat (2) @(posedge SYS_CLK);
        chk("irq clear", {31'h0, IRQ}, 32'h0);
        $display("irq test done");
        ctl(3'h7);
        repeat (3) @(posedge SYS_CLK);
        k = 0;
        for (i = 0; i < 30; i = i + 1) begin
            @(posedge SYS_CLK);
            #1;
            k = k + ENC_POLL_REQ;
        end
        chk("polls", k, 0);
        sc(32'h780);
        ctl(3'h3);
        lo = 32'h12C;
        wr(`EPCS_OFS_LOW_LIM, lo);
        repeat (3) @(posedge SYS_CLK);
        sc(32'h780);
        lo = 32'h1E;
        wr(`EPCS_OFS_LOW_LIM, lo);
        repeat (3) @(posedge SYS_CLK);
        sc(32'h780);
        $display("halt test done");
        enc(cur);
        @(posedge SYS_CLK) ENC_SIGNAL_OK <= 1'b0;
        flt = 1'b1;
        repeat (3) @(posedge SYS_CLK);
        sc(32'h800);
        @(posedge SYS_CLK) ENC_SIGNAL_OK <= 1'b1;
        mute = 1'b1;
        repeat (30) @(posedge SYS_CLK);
        sc(32'h800);
        mute = 1'b0;
        flt = 1'b0;
        enc(cur);
        sc(32'hFFFFFFFF);
        wr(`EPCS_OFS_DIAG_EN, 32'h5);
        dg = 4'h5;
        st_in = 4'h4;
        enc(cur);
        sc(32'hF1000);
        st_in = 4'h2;
        enc(cur);
        sc(32'hF1000);
        $display("fault and diag test done");
        conclude;
    end
endmodule // test_epcs_top
